//--- rtl/ums_modem_status.sv
/*
 * Modem line status block of a UART with an APB3 slave holding the
 * status register and the modem line control register (loopback source).
 * Assumes modem inputs are asynchronous pins; APB on clk.
 */
// Summary of operation
// - The status register is read-only and its change flags clear after a software read of it.
// - Bit 0 sets on any change of the clear-to-send input and clears on a status read.
// - Bit 1 sets on any change of the data-set-ready input and clears on a status read.
// - Bit 2 sets only on a low-to-high ring input transition and clears on a status read.
// - Bit 3 sets on any change of the carrier-detect input and clears on a status read.
// - The clear-to-send level is the inverted pin, or control bit 1 in loopback.
// - The data-set-ready level is the inverted pin, or control bit 0 in loopback.
// - The ring level is the inverted pin, or control bit 2 in loopback.
// - The carrier-detect level is the inverted pin, or control bit 3 in loopback.
// - Level bits sit at 4 to 7 as clear-to-send, data-set-ready, ring, carrier-detect.
`timescale 1ns/100ps
module ums_modem_status (
	input wire logic clk,
	input wire logic sys_rst,
	input ums_pkg::ums_apb_req_t apbReq,
	output ums_pkg::ums_apb_rsp_t apbRsp,
	input wire logic clearToSendIn,
	input wire logic setReadyIn,
	input wire logic ringIn,
	input wire logic carrierIn,
	output logic [3:0] modemCtrl
);
	import ums_pkg::*;

	typedef struct packed {
		logic [4:0] mlc;
		logic [3:0] chg;
		logic [3:0] prevIn;
		logic [1:0] warm;
		ums_apb_rsp_t rsp;
	} ums_state_t;

	ums_state_t st_r;
	ums_state_t st_nxt;

	logic [3:0] pinRaw;
	logic [3:0] pinSync;
	logic [3:0] inEff;
	logic [3:0] edgeSeen;
	logic [7:0] statusVal;
	logic loopOn;
	logic armed;
	logic accStart;
	logic accDone;
	logic hitStatus;
	logic hitMlc;
	logic readClr;

	assign pinRaw = {carrierIn, ringIn, setReadyIn, clearToSendIn};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			ums_line_sync u_sync (
				.clk(clk),
				.sys_rst(sys_rst),
				.lineIn(pinRaw[gi]),
				.lineSync(pinSync[gi])
			);
		end
	endgenerate

	always_comb begin
		loopOn = st_r.mlc[UMS_MLC_LOOP];
		// Pin polarity; loopback feeds the inverse so level bits equal control bits
		if (loopOn) begin
			inEff[UMS_CTS] = ~st_r.mlc[UMS_MLC_CTS_SRC];
			inEff[UMS_DSR] = ~st_r.mlc[UMS_MLC_DSR_SRC];
			inEff[UMS_RI] = ~st_r.mlc[UMS_MLC_RI_SRC];
			inEff[UMS_DCD] = ~st_r.mlc[UMS_MLC_DCD_SRC];
		end else begin
			inEff = pinSync;
		end
		// Hold off until the synchronisers hold real pin values
		armed = (st_r.warm == UMS_WARM_DONE);
		edgeSeen = armed ? (inEff ^ st_r.prevIn) : 4'h0;
		edgeSeen[UMS_RI] = armed & inEff[UMS_RI] & ~st_r.prevIn[UMS_RI];
		statusVal = {~inEff, st_r.chg};
	end

	always_comb begin
		accStart = apbReq.psel & apbReq.penable & ~st_r.rsp.pready;
		accDone = apbReq.psel & apbReq.penable & st_r.rsp.pready;
		hitStatus = (apbReq.paddr == UMS_STATUS_ADDR);
		hitMlc = (apbReq.paddr == UMS_MLC_ADDR);
		readClr = accDone & ~apbReq.pwrite & hitStatus;

		st_nxt = st_r;
		st_nxt.prevIn = inEff;
		st_nxt.warm = armed ? st_r.warm : st_r.warm + 2'h1;
		// Clear only what the read returned, so a change after the capture survives
		st_nxt.chg = (st_r.chg & ~(readClr ? st_r.rsp.prdata[3:0] : 4'h0)) | edgeSeen;

		st_nxt.rsp.pready = accStart;
		if (accStart) begin
			st_nxt.rsp.pslverr = ~(hitStatus | hitMlc);
			if (apbReq.pwrite) begin
				st_nxt.rsp.prdata = 32'h00000000;
			end else if (hitStatus) begin
				st_nxt.rsp.prdata = {24'h000000, statusVal};
			end else if (hitMlc) begin
				st_nxt.rsp.prdata = {27'h0000000, st_r.mlc};
			end else begin
				st_nxt.rsp.prdata = 32'h00000000;
			end
		end else if (accDone) begin
			st_nxt.rsp.pslverr = 1'b0;
		end
		// Writes to the status address are ignored without error
		if (accDone & apbReq.pwrite & hitMlc) begin
			st_nxt.mlc = apbReq.pwdata[4:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '{mlc: UMS_MLC_RST, chg: UMS_CHG_RST, prevIn: 4'h0, warm: 2'h0,
				rsp: '{prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0}};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign apbRsp = st_r.rsp;
	assign modemCtrl = st_r.mlc[3:0];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	property p_read_clears;
		readClr && st_r.rsp.prdata[3:0] == st_r.chg && edgeSeen == 4'h0 |=> st_r.chg == 4'h0;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("flags not cleared by status read");

	property p_write_ignored;
		accDone && apbReq.pwrite && hitStatus && edgeSeen == 4'h0 |=> $stable(st_r.chg) && $stable(st_r.mlc);
	endproperty
	a_write_ignored: assert property (p_write_ignored) else $error("status write changed state");

	property p_cts_change;
		armed && (inEff[UMS_CTS] != st_r.prevIn[UMS_CTS]) |=> st_r.chg[UMS_CTS];
	endproperty
	a_cts_change: assert property (p_cts_change) else $error("cts change not flagged");

	property p_dsr_change;
		armed && $changed(inEff[UMS_DSR]) && $past(armed) |-> ##1 st_r.chg[UMS_DSR];
	endproperty
	a_dsr_change: assert property (p_dsr_change) else $error("dsr change not flagged");

	property p_ri_fall_quiet;
		!st_r.chg[UMS_RI] && !inEff[UMS_RI] |=> !st_r.chg[UMS_RI];
	endproperty
	a_ri_fall_quiet: assert property (p_ri_fall_quiet) else $error("ring flag set without rising edge");

	property p_dcd_change;
		armed && (inEff[UMS_DCD] ^ st_r.prevIn[UMS_DCD]) |=> st_r.chg[UMS_DCD] ##1 (st_r.chg[UMS_DCD] || $past(readClr));
	endproperty
	a_dcd_change: assert property (p_dcd_change) else $error("dcd flag lost");

	property p_cts_level;
		accStart && !apbReq.pwrite && hitStatus |=>
			st_r.rsp.prdata[UMS_LVL_LSB] == ($past(loopOn) ? $past(st_r.mlc[UMS_MLC_CTS_SRC]) : !$past(pinSync[UMS_CTS]));
	endproperty
	a_cts_level: assert property (p_cts_level) else $error("cts level wrong");

	property p_loop_levels;
		accStart && !apbReq.pwrite && hitStatus && loopOn |=>
			st_r.rsp.prdata[7:5] == $past({st_r.mlc[UMS_MLC_DCD_SRC], st_r.mlc[UMS_MLC_RI_SRC], st_r.mlc[UMS_MLC_DSR_SRC]});
	endproperty
	a_loop_levels: assert property (p_loop_levels) else $error("loopback levels wrong");

	property p_pin_levels;
		accStart && !apbReq.pwrite && hitStatus && !loopOn |=> st_r.rsp.prdata[7:5] == ~$past(pinSync[3:1]);
	endproperty
	a_pin_levels: assert property (p_pin_levels) else $error("pin levels wrong");

	property p_no_loss;
		readClr && edgeSeen != 4'h0 |=> (st_r.chg & $past(edgeSeen)) == $past(edgeSeen);
	endproperty
	a_no_loss: assert property (p_no_loss) else $error("change lost during read clear");

	property p_ri_rise;
		armed && inEff[UMS_RI] && !st_r.prevIn[UMS_RI] |=> st_r.chg[UMS_RI];
	endproperty
	a_ri_rise: assert property (p_ri_rise) else $error("ring rise not flagged");

	// Flags are sticky: only a completed status read may drop them
	property p_cts_sticky;
		st_r.chg[UMS_CTS] && !readClr |=> st_r.chg[UMS_CTS];
	endproperty
	a_cts_sticky: assert property (p_cts_sticky) else $error("cts flag dropped without read");

	property p_cts_quiet;
		!st_r.chg[UMS_CTS] && !(armed && inEff[UMS_CTS] != st_r.prevIn[UMS_CTS]) |=> !st_r.chg[UMS_CTS];
	endproperty
	a_cts_quiet: assert property (p_cts_quiet) else $error("cts flag set without change");

	property p_dsr_quiet;
		!st_r.chg[UMS_DSR] && !(armed && inEff[UMS_DSR] != st_r.prevIn[UMS_DSR]) |=> !st_r.chg[UMS_DSR];
	endproperty
	a_dsr_quiet: assert property (p_dsr_quiet) else $error("dsr flag set without change");

	property p_dcd_quiet;
		!st_r.chg[UMS_DCD] && !(armed && inEff[UMS_DCD] != st_r.prevIn[UMS_DCD]) |=> !st_r.chg[UMS_DCD];
	endproperty
	a_dcd_quiet: assert property (p_dcd_quiet) else $error("dcd flag set without change");

	property p_status_write_ok;
		accStart && apbReq.pwrite && hitStatus |=> st_r.rsp.pready && !st_r.rsp.pslverr;
	endproperty
	a_status_write_ok: assert property (p_status_write_ok) else $error("status write answered wrongly");

	// Capture edge must not clear; clearing waits for the completed transfer
	property p_keep_until_done;
		accStart && !apbReq.pwrite && hitStatus |=> (st_r.chg & $past(st_r.chg)) == $past(st_r.chg);
	endproperty
	a_keep_until_done: assert property (p_keep_until_done) else $error("flags cleared before read done");

endmodule : ums_modem_status

//--- rtl/ums_pkg.sv
/*
 * Package for the modem line status block: register addresses, field
 * positions, reset values and the APB carrier structs.
 * Assumes a 32-bit APB3 master with full-word accesses.
 */
package ums_pkg;

	localparam logic [31:0] UMS_MLC_ADDR = 32'h40008010;
	localparam logic [31:0] UMS_STATUS_ADDR = 32'h40008018;

	// Status register fields
	localparam int UMS_CHG_LSB = 0;
	localparam int UMS_LVL_LSB = 4;
	// Line index, same order for change and level fields
	localparam int UMS_CTS = 0;
	localparam int UMS_DSR = 1;
	localparam int UMS_RI = 2;
	localparam int UMS_DCD = 3;

	// Modem line control fields
	localparam int UMS_MLC_DSR_SRC = 0;
	localparam int UMS_MLC_CTS_SRC = 1;
	localparam int UMS_MLC_RI_SRC = 2;
	localparam int UMS_MLC_DCD_SRC = 3;
	localparam int UMS_MLC_LOOP = 4;
	localparam logic [4:0] UMS_MLC_RST = 5'h00;

	localparam logic [3:0] UMS_CHG_RST = 4'h0;
	localparam logic [1:0] UMS_WARM_DONE = 2'h3;

	typedef struct packed {
		logic [31:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} ums_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ums_apb_rsp_t;

	typedef struct packed {
		logic meta;
		logic stable;
	} ums_sync_t;

endpackage : ums_pkg

//--- rtl/ums_line_sync.sv
/*
 * Two-flop synchroniser for one asynchronous modem line.
 * Assumes the line is a slow level from a pin, no glitch filtering.
 */
`timescale 1ns/100ps
module ums_line_sync (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic lineIn,
	output logic lineSync
);
	import ums_pkg::*;

	ums_sync_t st_r;
	ums_sync_t st_nxt;

	always_comb begin
		st_nxt.meta = lineIn;
		// Only the second stage looks at the first
		st_nxt.stable = st_r.meta;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '{meta: 1'b0, stable: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign lineSync = st_r.stable;

endmodule : ums_line_sync

//--- tb/ums_modem_model.sv
/* Modem partner: drives the four handshake pins from requested levels.
 * Assumes the bench changes requests right after a rising edge. */
`timescale 1ns/100ps
module ums_modem_model (
	input wire logic clk,
	input wire logic [3:0] wantLines,
	output logic [3:0] lines
);
	// Pins lag a cycle, so the bench never relies on instant edges
	always_ff @(posedge clk) begin
		lines <= wantLines;
	end
endmodule : ums_modem_model

//--- tb/test_ums_modem_status.sv
/* Bench for the modem line status block: pin changes, reads, loopback.
 * Assumes an APB slave that answers within a few cycles. */
`timescale 1ns/100ps
module test_ums_modem_status;
	import ums_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	ums_apb_req_t apbReq = '0;
	ums_apb_rsp_t apbRsp;
	logic [3:0] wantLines = 4'h0;
	logic [3:0] lines;
	logic [3:0] modemCtrl;
	logic [31:0] rd;
	logic err;
	logic [3:0] prev;
	logic [4:0] ctl;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;
	always #4 clk = ~clk;
	ums_modem_model ums_modem_model_i (.clk(clk), .wantLines(wantLines), .lines(lines));
	ums_modem_status ums_modem_status_i (.clk(clk), .sys_rst(sys_rst), .apbReq(apbReq), .apbRsp(apbRsp),
		.clearToSendIn(lines[0]), .setReadyIn(lines[1]), .ringIn(lines[2]), .carrierIn(lines[3]),
		.modemCtrl(modemCtrl));
	task automatic summarize();
		if (miscompares == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// Leading edge wait keeps two transfers from driving psel in one step
	task automatic apb(input logic [31:0] addr, input logic wr, input logic [31:0] wdata);
		@(posedge clk);
		apbReq.paddr <= addr;
		apbReq.pwrite <= wr;
		apbReq.pwdata <= wdata;
		apbReq.psel <= 1'b1;
		@(posedge clk);
		apbReq.penable <= 1'b1;
		// No cycle count assumed; only the bench timeout ends a hung wait
		do begin
			@(posedge clk);
		end while (apbRsp.pready !== 1'b1);
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask : apb
	function automatic logic [7:0] expStatus(input logic [3:0] was, input logic [3:0] now);
		logic [3:0] chg;
		chg = was ^ now;
		chg[UMS_RI] = ~was[UMS_RI] & now[UMS_RI];
		return {~now, chg};
	endfunction : expStatus
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			miscompares = miscompares + 1;
			summarize();
		end
	end
	initial begin
		void'($urandom(32'h19CC96C4));
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (8) @(posedge clk);
		prev = 4'h0;
		apb(UMS_STATUS_ADDR, 1'b0, 32'h0);
		chk("status idle", rd, {24'h0, expStatus(prev, prev)});
		for (int i = 0; i < 40; i++) begin
			// All rise, then all fall: a falling ring must stay unflagged
			wantLines <= (i == 0) ? 4'hF : (i == 1) ? 4'h0 : 4'($urandom);
			repeat (8) @(posedge clk);
			apb(UMS_STATUS_ADDR, 1'b0, 32'h0);
			chk("status flags", rd, {24'h0, expStatus(prev, wantLines)});
			apb(UMS_STATUS_ADDR, 1'b1, $urandom);
			chk("status write err", {31'h0, err}, 32'h0);
			apb(UMS_STATUS_ADDR, 1'b0, 32'h0);
			chk("status cleared", rd, {24'h0, ~wantLines, 4'h0});
			prev = wantLines;
		end
		apb(32'h40008014, 1'b0, 32'h0);
		chk("unmapped err", {31'h0, err}, 32'h1);
		for (int i = 0; i < 8; i++) begin
			ctl = {1'b1, 4'($urandom)};
			apb(UMS_MLC_ADDR, 1'b1, {27'h7FFFFFF, ctl});
			apb(UMS_MLC_ADDR, 1'b0, 32'h0);
			chk("control readback", rd, {27'h0, ctl});
			apb(UMS_STATUS_ADDR, 1'b0, 32'h0);
			chk("control out", {28'h0, modemCtrl}, {28'h0, ctl[3:0]});
			chk("loop level", rd & 32'hF0, {24'h0, ctl[3], ctl[2], ctl[0], ctl[1], 4'h0});
		end
		apb(UMS_MLC_ADDR, 1'b1, 32'h0);
		apb(UMS_STATUS_ADDR, 1'b0, 32'h0);
		chk("pin level back", rd & 32'hF0, {24'h0, ~prev, 4'h0});
		// Pins flip so the edge reaches the flags on the edge that ends this read
		wantLines <= ~prev;
		apb(UMS_STATUS_ADDR, 1'b0, 32'h0);
		chk("read during change", rd, {24'h0, ~prev, 4'h0});
		apb(UMS_STATUS_ADDR, 1'b0, 32'h0);
		chk("change kept", rd, {24'h0, expStatus(prev, ~prev)});
		summarize();
	end
endmodule : test_ums_modem_status
